//--- cops_top.sv
// Clock output pin select: port 2 and port 3 registers and pin drivers.
// Assumes fast_clock and slow_clock arrive asynchronously and are far slower
// than mclk; a byte-wide register port with one-cycle strobes.
`timescale 1ns/10ps
`default_nettype none

module cops_top #(
  parameter int unsigned SYNC_STAGES = 2
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [15:0]           reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output var  logic [7:0]            reg_rdata,
  input  wire logic                  fast_clock,
  input  wire logic                  slow_clock,
  output var  logic [1:0]            p2_pin_out,
  output var  logic [1:0]            p2_pin_oe,
  output var  logic [6:0]            p3_pin_out,
  output var  logic [6:0]            p3_pin_oe
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (SYNC_STAGES != 2) begin : g_bad_sync
    $error("SYNC_STAGES must be 2");
  end

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic logic [3:0] reg_index(input logic [15:0] addr);
    case (addr)
      cops_pkg::OFS_P2_VALUE:     reg_index = 4'h0;
      cops_pkg::OFS_P2_DRIVE_LO:  reg_index = 4'h1;
      cops_pkg::OFS_P2_DRIVE_HI:  reg_index = 4'h2;
      cops_pkg::OFS_P2_FUNC:      reg_index = 4'h3;
      cops_pkg::OFS_P3_VALUE:     reg_index = 4'h4;
      cops_pkg::OFS_P3_DIR:       reg_index = 4'h5;
      cops_pkg::OFS_P3_DRIVE_HI:  reg_index = 4'h6;
      cops_pkg::OFS_P3_DRIVE_LO:  reg_index = 4'h7;
      cops_pkg::OFS_P3_FUNC_LO:   reg_index = 4'h8;
      cops_pkg::OFS_P3_FUNC_HI:   reg_index = 4'h9;
      cops_pkg::OFS_P2_PIN_STATE: reg_index = 4'hA;
      cops_pkg::OFS_P3_PIN_STATE: reg_index = 4'hB;
      default:                    reg_index = 4'hF;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Port registers
  // --------------------------------------------------------------------------
  logic [1:0] p2_value_q;
  logic [1:0] p2_value_d;
  logic [1:0] p2_drv_lo_q;
  logic [1:0] p2_drv_lo_d;
  logic [1:0] p2_drv_hi_q;
  logic [1:0] p2_drv_hi_d;
  logic [1:0] p2_func_q;
  logic [1:0] p2_func_d;
  logic [6:0] p3_value_q;
  logic [6:0] p3_value_d;
  logic [6:0] p3_dir_q;
  logic [6:0] p3_dir_d;
  logic [6:0] p3_drv_hi_q;
  logic [6:0] p3_drv_hi_d;
  logic [6:0] p3_drv_lo_q;
  logic [6:0] p3_drv_lo_d;
  logic [6:0] p3_func_lo_q;
  logic [6:0] p3_func_lo_d;
  logic [6:0] p3_func_hi_q;
  logic [6:0] p3_func_hi_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;

  always_comb begin
    wr_idx       = reg_index(reg_addr);
    rd_idx       = reg_index(reg_addr);
    p2_value_d   = p2_value_q;
    p2_drv_lo_d  = p2_drv_lo_q;
    p2_drv_hi_d  = p2_drv_hi_q;
    p2_func_d    = p2_func_q;
    p3_value_d   = p3_value_q;
    p3_dir_d     = p3_dir_q;
    p3_drv_hi_d  = p3_drv_hi_q;
    p3_drv_lo_d  = p3_drv_lo_q;
    p3_func_lo_d = p3_func_lo_q;
    p3_func_hi_d = p3_func_hi_q;
    if (reg_wr) begin
      case (wr_idx)
        4'h0:    p2_value_d   = reg_wdata[1:0];
        4'h1:    p2_drv_lo_d  = reg_wdata[1:0];
        4'h2:    p2_drv_hi_d  = reg_wdata[1:0];
        4'h3:    p2_func_d    = reg_wdata[1:0];
        4'h4:    p3_value_d   = reg_wdata[6:0];
        4'h5:    p3_dir_d     = reg_wdata[6:0];
        4'h6:    p3_drv_hi_d  = reg_wdata[6:0];
        4'h7:    p3_drv_lo_d  = reg_wdata[6:0];
        4'h8:    p3_func_lo_d = reg_wdata[6:0];
        4'h9:    p3_func_hi_d = reg_wdata[6:0];
        default: p2_value_d   = p2_value_q;
      endcase
    end
    // Missing bits read as zero; unmapped reads return zero
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (rd_idx)
        4'h0:    rdata_d = {6'h00, p2_value_q};
        4'h1:    rdata_d = {6'h00, p2_drv_lo_q};
        4'h2:    rdata_d = {6'h00, p2_drv_hi_q};
        4'h3:    rdata_d = {6'h00, p2_func_q};
        4'h4:    rdata_d = {1'b0, p3_value_q};
        4'h5:    rdata_d = {1'b0, p3_dir_q};
        4'h6:    rdata_d = {1'b0, p3_drv_hi_q};
        4'h7:    rdata_d = {1'b0, p3_drv_lo_q};
        4'h8:    rdata_d = {1'b0, p3_func_lo_q};
        4'h9:    rdata_d = {1'b0, p3_func_hi_q};
        4'hA:    rdata_d = {6'h00, p2_pin_out};
        4'hB:    rdata_d = {1'b0, p3_pin_out};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      p2_value_q   <= cops_pkg::RST_P2_VALUE;
      p2_drv_lo_q  <= cops_pkg::RST_P2_DRIVE_LO;
      p2_drv_hi_q  <= cops_pkg::RST_P2_DRIVE_HI;
      p2_func_q    <= cops_pkg::RST_P2_FUNC;
      p3_value_q   <= cops_pkg::RST_P3_VALUE;
      p3_dir_q     <= cops_pkg::RST_P3_DIR;
      p3_drv_hi_q  <= cops_pkg::RST_P3_DRIVE_HI;
      p3_drv_lo_q  <= cops_pkg::RST_P3_DRIVE_LO;
      p3_func_lo_q <= cops_pkg::RST_P3_FUNC_LO;
      p3_func_hi_q <= cops_pkg::RST_P3_FUNC_HI;
      rdata_q      <= 8'h00;
    end else begin
      p2_value_q   <= p2_value_d;
      p2_drv_lo_q  <= p2_drv_lo_d;
      p2_drv_hi_q  <= p2_drv_hi_d;
      p2_func_q    <= p2_func_d;
      p3_value_q   <= p3_value_d;
      p3_dir_q     <= p3_dir_d;
      p3_drv_hi_q  <= p3_drv_hi_d;
      p3_drv_lo_q  <= p3_drv_lo_d;
      p3_func_lo_q <= p3_func_lo_d;
      p3_func_hi_q <= p3_func_hi_d;
      rdata_q      <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // --------------------------------------------------------------------------
  // Clock synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] fast_sync_q;
  logic [1:0] fast_sync_d;
  logic [1:0] slow_sync_q;
  logic [1:0] slow_sync_d;
  logic       fast_s;
  logic       slow_s;

  always_comb begin
    fast_sync_d = {fast_sync_q[0], fast_clock};
    slow_sync_d = {slow_sync_q[0], slow_clock};
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fast_sync_q <= 2'h0;
      slow_sync_q <= 2'h0;
    end else begin
      fast_sync_q <= fast_sync_d;
      slow_sync_q <= slow_sync_d;
    end
  end

  assign fast_s = fast_sync_q[1];
  assign slow_s = slow_sync_q[1];

  // --------------------------------------------------------------------------
  // Pin control and drivers
  // --------------------------------------------------------------------------
  cops_pkg::cops_pin_ctrl_t p2_ctrl [cops_pkg::P2_PINS];
  cops_pkg::cops_pin_ctrl_t p3_ctrl [cops_pkg::P3_PINS];
  cops_pkg::cops_func_t     p3_func [cops_pkg::P3_PINS];

  for (genvar i = 0; i < cops_pkg::P2_PINS; i++) begin : g_p2
    always_comb begin
      p2_ctrl[i].clk_sel = p2_func_q[i];
      p2_ctrl[i].clk_val = (i == cops_pkg::FAST_PIN_BIT) ? fast_s : slow_s;
      p2_ctrl[i].value   = p2_value_q[i];
      p2_ctrl[i].drive   = cops_pkg::cops_drive_t'({p2_drv_hi_q[i], p2_drv_lo_q[i]});
      p2_ctrl[i].dir_out = 1'b1;
    end
    cops_pin_cell u_cell (
      .mclk    (mclk),
      .rst     (rst),
      .ctrl    (p2_ctrl[i]),
      .pin_out (p2_pin_out[i]),
      .pin_oe  (p2_pin_oe[i])
    );
  end

  for (genvar i = 0; i < cops_pkg::P3_PINS; i++) begin : g_p3
    always_comb begin
      p3_func[i]         = cops_pkg::cops_func_t'({p3_func_hi_q[i], p3_func_lo_q[i]});
      // Only pin 6 has the slow clock as second function
      p3_ctrl[i].clk_sel = (i == cops_pkg::SLOW_PIN_B_BIT) &&
                           (p3_func[i] == cops_pkg::FUNC_SECOND);
      p3_ctrl[i].clk_val = slow_s;
      p3_ctrl[i].value   = p3_value_q[i];
      p3_ctrl[i].drive   = cops_pkg::cops_drive_t'({p3_drv_hi_q[i], p3_drv_lo_q[i]});
      p3_ctrl[i].dir_out = ~p3_dir_q[i];
    end
    cops_pin_cell u_cell (
      .mclk    (mclk),
      .rst     (rst),
      .ctrl    (p3_ctrl[i]),
      .pin_out (p3_pin_out[i]),
      .pin_oe  (p3_pin_oe[i])
    );
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic fast_cmos;
  logic slow_a_cmos;
  logic slow_b_cmos;
  logic slow_b_sel;
  assign fast_cmos   = p2_drv_hi_q[1] & p2_drv_lo_q[1];
  assign slow_a_cmos = p2_drv_hi_q[0] & p2_drv_lo_q[0];
  assign slow_b_cmos = p3_drv_hi_q[6] & p3_drv_lo_q[6];
  assign slow_b_sel  = !p3_func_hi_q[6] && p3_func_lo_q[6];

  a_fast_clock_route: assert property (
    (p2_func_q[1] && fast_cmos) |=> (p2_pin_out[1] == $past(fast_s)) && p2_pin_oe[1])
    else $error("fast clock not on port-2 pin 1");
  a_fast_cmos_drive: assert property (
    fast_cmos |=> p2_pin_oe[1])
    else $error("port-2 pin 1 not driven in CMOS mode");
  a_fast_data_ignore: assert property (
    (p2_func_q[1] && fast_cmos && (p2_value_q[1] != fast_s)) |=>
      (p2_pin_out[1] != $past(p2_value_q[1])))
    else $error("port-2 data bit 1 leaked onto clock pin");
  a_slow_a_route: assert property (
    (p2_func_q[0] && slow_a_cmos) |=> (p2_pin_out[0] == $past(slow_s)))
    else $error("slow clock not on port-2 pin 0");
  a_slow_a_cmos: assert property (
    slow_a_cmos |=> p2_pin_oe[0])
    else $error("port-2 pin 0 not driven in CMOS mode");
  a_slow_a_ignore: assert property (
    (p2_func_q[0] && slow_a_cmos && (p2_value_q[0] != slow_s)) |=>
      (p2_pin_out[0] != $past(p2_value_q[0])))
    else $error("port-2 data bit 0 leaked onto clock pin");
  a_slow_b_route: assert property (
    (slow_b_sel && slow_b_cmos && !p3_dir_q[6]) |=> (p3_pin_out[6] == $past(slow_s)))
    else $error("slow clock not on port-3 pin 6");
  a_slow_b_cmos: assert property (
    (slow_b_cmos && !p3_dir_q[6]) |=> p3_pin_oe[6])
    else $error("port-3 pin 6 not driven in CMOS mode");
  a_slow_b_dir: assert property (
    p3_dir_q[6] |=> !p3_pin_oe[6])
    else $error("port-3 pin 6 driven while set as input");
  a_slow_b_ignore: assert property (
    (slow_b_sel && slow_b_cmos && !p3_dir_q[6] && (p3_value_q[6] != slow_s)) |=>
      (p3_pin_out[6] != $past(p3_value_q[6])))
    else $error("port-3 data bit 6 leaked onto clock pin");
  a_gpio_follow: assert property (
    (!p2_func_q[0] && slow_a_cmos) ##1 (!p2_func_q[0] && slow_a_cmos) |=>
      (p2_pin_out[0] == $past(p2_value_q[0])))
    else $error("port-2 pin 0 does not follow its data bit");
  a_read_timing: assert property (
    (reg_rd && reg_index(reg_addr) == 4'hF) |=> (reg_rdata == 8'h00))
    else $error("unmapped read returned nonzero data");
  a_p2_od_out: assert property (
    ((p2_drv_hi_q[1] != p2_drv_lo_q[1]) && !p2_func_q[1] && !p2_value_q[1]) |=> p2_pin_oe[1])
    else $error("port-2 pin 1 not pulled low in open-drain mode");

  // --------------------------------------------------------------------------
  // Register port and reset checks
  // --------------------------------------------------------------------------
  a_rdata_idle: assert property (
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data stood outside its cycle");
  a_write_lands: assert property (
    (reg_wr && reg_addr == cops_pkg::OFS_P2_FUNC) |=> (p2_func_q == $past(reg_wdata[1:0])))
    else $error("port-2 function write did not land");
  a_dir_lands: assert property (
    (reg_wr && reg_addr == cops_pkg::OFS_P3_DIR) |=> (p3_dir_q == $past(reg_wdata[6:0])))
    else $error("port-3 direction write did not land");
  a_unmapped_write: assert property (
    (reg_wr && reg_index(reg_addr) == 4'hF) |=>
      $stable({p2_value_q, p2_drv_lo_q, p2_drv_hi_q, p2_func_q, p3_dir_q, p3_func_hi_q}))
    else $error("unmapped write changed a register");
  a_p2_state_read: assert property (
    (reg_rd && reg_addr == cops_pkg::OFS_P2_PIN_STATE) |=>
      (reg_rdata == {6'h00, $past(p2_pin_out)}))
    else $error("port-2 pin state read wrong");
  a_p3_state_read: assert property (
    (reg_rd && reg_addr == cops_pkg::OFS_P3_PIN_STATE) |=>
      (reg_rdata == {1'b0, $past(p3_pin_out)}))
    else $error("port-3 pin state read wrong");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> ((p2_pin_oe == 2'h0) && (p3_pin_oe == 7'h00) && (reg_rdata == 8'h00)))
    else $error("pins driven after reset");

  // --------------------------------------------------------------------------
  // Scenario covers
  // --------------------------------------------------------------------------

  c_fast_clock_out: cover property (p2_func_q[1] && fast_cmos ##1 $rose(p2_pin_out[1]));
  c_slow_a_out: cover property (p2_func_q[0] && slow_a_cmos ##1 $rose(p2_pin_out[0]));
  c_slow_b_out: cover property (slow_b_sel && slow_b_cmos && !p3_dir_q[6]
                                ##1 $rose(p3_pin_out[6]));
  c_slow_b_input: cover property (slow_b_sel && slow_b_cmos && p3_dir_q[6]);
  c_open_drain: cover property (p2_drv_hi_q[1] != p2_drv_lo_q[1]);

endmodule

`default_nettype wire

//--- cops_pkg.sv
// Shared constants and types of the clock output pin select block.
// Assumes one system clock and a byte-wide register port at the printed offsets.
package cops_pkg;

  // --------------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  localparam logic [15:0] OFS_P2_VALUE      = 16'hF210;
  localparam logic [15:0] OFS_P2_PIN_STATE  = 16'hF211;
  localparam logic [15:0] OFS_P2_DRIVE_LO   = 16'hF212;
  localparam logic [15:0] OFS_P2_DRIVE_HI   = 16'hF213;
  localparam logic [15:0] OFS_P2_FUNC       = 16'hF214;
  localparam logic [15:0] OFS_P3_VALUE      = 16'hF218;
  localparam logic [15:0] OFS_P3_DIR        = 16'hF219;
  localparam logic [15:0] OFS_P3_DRIVE_HI   = 16'hF21A;
  localparam logic [15:0] OFS_P3_DRIVE_LO   = 16'hF21B;
  localparam logic [15:0] OFS_P3_FUNC_LO    = 16'hF21C;
  localparam logic [15:0] OFS_P3_FUNC_HI    = 16'hF21D;
  localparam logic [15:0] OFS_P3_PIN_STATE  = 16'hF21E;

  // --------------------------------------------------------------------------
  // Field positions and widths
  // --------------------------------------------------------------------------
  localparam int unsigned P2_PINS        = 2;
  localparam int unsigned P3_PINS        = 7;
  localparam int unsigned FAST_PIN_BIT   = 1;
  localparam int unsigned SLOW_PIN_A_BIT = 0;
  localparam int unsigned SLOW_PIN_B_BIT = 6;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [1:0] RST_P2_VALUE    = 2'h0;
  localparam logic [1:0] RST_P2_DRIVE_LO = 2'h0;
  localparam logic [1:0] RST_P2_DRIVE_HI = 2'h0;
  localparam logic [1:0] RST_P2_FUNC     = 2'h0;
  localparam logic [6:0] RST_P3_VALUE    = 7'h00;
  localparam logic [6:0] RST_P3_DIR      = 7'h00;
  localparam logic [6:0] RST_P3_DRIVE_HI = 7'h00;
  localparam logic [6:0] RST_P3_DRIVE_LO = 7'h00;
  localparam logic [6:0] RST_P3_FUNC_LO  = 7'h00;
  localparam logic [6:0] RST_P3_FUNC_HI  = 7'h00;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DRV_HIZ  = 2'b00,
    DRV_OD_A = 2'b01,
    DRV_OD_B = 2'b10,
    DRV_CMOS = 2'b11
  } cops_drive_t;

  typedef enum logic [1:0] {
    FUNC_GPIO   = 2'b00,
    FUNC_SECOND = 2'b01,
    FUNC_THIRD  = 2'b10,
    FUNC_RSVD   = 2'b11
  } cops_func_t;

  typedef struct packed {
    logic        clk_sel;
    logic        clk_val;
    logic        value;
    cops_drive_t drive;
    logic        dir_out;
  } cops_pin_ctrl_t;

endpackage

//--- cops_pin_cell.sv
// One output pin: picks clock or data, applies drive mode, registers the pin.
// Assumes all control inputs are already in the mclk domain.
`timescale 1ns/10ps
`default_nettype none

module cops_pin_cell (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire cops_pkg::cops_pin_ctrl_t ctrl,
  output var  logic                     pin_out,
  output var  logic                     pin_oe
);

  logic src;
  logic out_d;
  logic oe_d;
  logic out_q;
  logic oe_q;

  always_comb begin
    // Data bit has no effect while the clock is selected
    src = ctrl.clk_sel ? ctrl.clk_val : ctrl.value;
    out_d = 1'b0;
    oe_d  = 1'b0;
    case (ctrl.drive)
      cops_pkg::DRV_CMOS: begin
        out_d = src;
        oe_d  = ctrl.dir_out;
      end
      cops_pkg::DRV_HIZ: begin
        out_d = 1'b0;
        oe_d  = 1'b0;
      end
      default: begin
        // Open drain: pulls low only
        out_d = 1'b0;
        oe_d  = ctrl.dir_out & ~src;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      out_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  assign pin_out = out_q;
  assign pin_oe  = oe_q;

endmodule

`default_nettype wire

//--- cops_pin_receiver.sv
// Far-side model of the board circuitry that receives the clock output pins.
// Assumes registered pin outputs far slower than mclk; undriven pins float up.
`timescale 1ns/10ps
`default_nettype none

module cops_pin_receiver (
  input  wire logic        mclk,
  input  wire logic        clr,
  input  wire logic [1:0]  p2_pin_out,
  input  wire logic [1:0]  p2_pin_oe,
  input  wire logic [6:0]  p3_pin_out,
  input  wire logic [6:0]  p3_pin_oe,
  output var  logic [2:0]  pin_level,
  output var  logic [15:0] fast_rises,
  output var  logic [15:0] slow_a_rises,
  output var  logic [15:0] slow_b_rises
);
  // --------------------------------------------------------------------------
  // Wire levels with board pull-ups
  // --------------------------------------------------------------------------
  logic [2:0] level_q;

  always_comb begin
    pin_level[2] = p3_pin_oe[6] ? p3_pin_out[6] : 1'b1;
    pin_level[1] = p2_pin_oe[1] ? p2_pin_out[1] : 1'b1;
    pin_level[0] = p2_pin_oe[0] ? p2_pin_out[0] : 1'b1;
  end

  // --------------------------------------------------------------------------
  // Rising edge counters
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    level_q <= pin_level;
    if (clr) begin
      fast_rises   <= 16'h0000;
      slow_a_rises <= 16'h0000;
      slow_b_rises <= 16'h0000;
    end else begin
      fast_rises   <= fast_rises + {15'h0000, pin_level[1] & ~level_q[1]};
      slow_a_rises <= slow_a_rises + {15'h0000, pin_level[0] & ~level_q[0]};
      slow_b_rises <= slow_b_rises + {15'h0000, pin_level[2] & ~level_q[2]};
    end
  end
endmodule
`default_nettype wire

//--- tb_cops_top.sv
// Self-checking bench of the clock output pin select block.
// Assumes the far-side receiver model and the design package are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb_cops_top;
  typedef struct packed {
    logic [1:0] f2;
    logic [1:0] dh2;
    logic [1:0] dl2;
    logic [1:0] v2;
    logic [5:0] p3;
    logic [1:0] clk;
    logic [1:0] e2o;
    logic [1:0] e2e;
    logic [1:0] e3;
  } cops_row_t;

  logic        mclk;
  logic        rst;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        fast_clock;
  logic        slow_clock;
  logic [1:0]  p2_pin_out;
  logic [1:0]  p2_pin_oe;
  logic [6:0]  p3_pin_out;
  logic [6:0]  p3_pin_oe;
  logic        clr;
  logic [2:0]  pin_level;
  logic [15:0] fast_rises;
  logic [15:0] slow_a_rises;
  logic [15:0] slow_b_rises;
  int          n_fail;
  int          n_checks;
  logic [7:0]  rd_val;

  localparam logic [15:0] REGS [10] = '{cops_pkg::OFS_P2_VALUE, cops_pkg::OFS_P2_DRIVE_LO,
    cops_pkg::OFS_P2_DRIVE_HI, cops_pkg::OFS_P2_FUNC, cops_pkg::OFS_P3_VALUE,
    cops_pkg::OFS_P3_DIR, cops_pkg::OFS_P3_DRIVE_HI, cops_pkg::OFS_P3_DRIVE_LO,
    cops_pkg::OFS_P3_FUNC_LO, cops_pkg::OFS_P3_FUNC_HI};

  // p3 field: {mode_hi, mode_lo, direction, drive_hi, drive_lo, value} of pin 6
  cops_row_t rows [9] = '{
    '{2'h0, 2'h3, 2'h3, 2'h2, 6'h07, 2'h1, 2'h2, 2'h3, 2'h3},
    '{2'h2, 2'h3, 2'h3, 2'h0, 6'h17, 2'h2, 2'h2, 2'h3, 2'h1},
    '{2'h2, 2'h3, 2'h3, 2'h2, 6'h16, 2'h1, 2'h0, 2'h3, 2'h3},
    '{2'h1, 2'h3, 2'h3, 2'h0, 6'h36, 2'h1, 2'h1, 2'h3, 2'h1},
    '{2'h1, 2'h3, 2'h3, 2'h1, 6'h27, 2'h2, 2'h0, 2'h3, 2'h3},
    '{2'h3, 2'h3, 2'h3, 2'h0, 6'h1E, 2'h3, 2'h3, 2'h3, 2'h2},
    '{2'h3, 2'h0, 2'h0, 2'h0, 6'h10, 2'h3, 2'h0, 2'h0, 2'h0},
    '{2'h3, 2'h3, 2'h0, 2'h0, 6'h14, 2'h2, 2'h0, 2'h1, 2'h1},
    '{2'h0, 2'h0, 2'h3, 2'h1, 6'h03, 2'h0, 2'h0, 2'h2, 2'h0}};

  cops_top i_cops_top (
    .mclk       (mclk),
    .rst        (rst),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .fast_clock (fast_clock),
    .slow_clock (slow_clock),
    .p2_pin_out (p2_pin_out),
    .p2_pin_oe  (p2_pin_oe),
    .p3_pin_out (p3_pin_out),
    .p3_pin_oe  (p3_pin_oe)
  );

  cops_pin_receiver i_cops_pin_receiver (
    .mclk         (mclk),
    .clr          (clr),
    .p2_pin_out   (p2_pin_out),
    .p2_pin_oe    (p2_pin_oe),
    .p3_pin_out   (p3_pin_out),
    .p3_pin_oe    (p3_pin_oe),
    .pin_level    (pin_level),
    .fast_rises   (fast_rises),
    .slow_a_rises (slow_a_rises),
    .slow_b_rises (slow_b_rises)
  );

  // --------------------------------------------------------------------------
  // Clock, bus tasks and checks
  // --------------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask

  task automatic reg_write(input logic [15:0] addr, input logic [7:0] data);
    reg_wr    <= 1'b1;
    reg_addr  <= addr;
    reg_wdata <= data;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  // Data stands one cycle only, then must fall back to zero
  task automatic reg_read(input logic [15:0] addr, output logic [7:0] data);
    reg_rd   <= 1'b1;
    reg_addr <= addr;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    data = reg_rdata;
    @(posedge mclk);
    @(negedge mclk);
    chk("rdata idle", 16'h0000, {8'h00, reg_rdata});
    @(posedge mclk);
  endtask

  function automatic logic [7:0] b6(input logic b);
    return {1'b0, b, 6'h00};
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    stop_test();
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    n_fail = 0;
    n_checks = 0;
    rst = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fast_clock = 1'b0;
    slow_clock = 1'b0;
    clr = 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (REGS[i]) begin
      reg_read(REGS[i], rd_val);
      chk("reset value", 16'h0000, {8'h00, rd_val});
    end
    $display("test reset done");

    foreach (rows[i]) begin
      fast_clock <= rows[i].clk[1];
      slow_clock <= rows[i].clk[0];
      reg_write(cops_pkg::OFS_P2_FUNC, {6'h00, rows[i].f2});
      reg_write(cops_pkg::OFS_P2_DRIVE_HI, {6'h00, rows[i].dh2});
      reg_write(cops_pkg::OFS_P2_DRIVE_LO, {6'h00, rows[i].dl2});
      reg_write(cops_pkg::OFS_P2_VALUE, {6'h00, rows[i].v2});
      reg_write(cops_pkg::OFS_P3_FUNC_HI, b6(rows[i].p3[5]));
      reg_write(cops_pkg::OFS_P3_FUNC_LO, b6(rows[i].p3[4]));
      reg_write(cops_pkg::OFS_P3_DIR, b6(rows[i].p3[3]));
      reg_write(cops_pkg::OFS_P3_DRIVE_HI, b6(rows[i].p3[2]));
      reg_write(cops_pkg::OFS_P3_DRIVE_LO, b6(rows[i].p3[1]));
      reg_write(cops_pkg::OFS_P3_VALUE, b6(rows[i].p3[0]));
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk("p2_pin_out", {14'h0000, rows[i].e2o}, {14'h0000, p2_pin_out});
      chk("p2_pin_oe", {14'h0000, rows[i].e2e}, {14'h0000, p2_pin_oe});
      chk("p3_pin_out", {9'h000, rows[i].e3[1], 6'h00}, {9'h000, p3_pin_out});
      chk("p3_pin_oe", {9'h000, rows[i].e3[0], 6'h00}, {9'h000, p3_pin_oe});
      @(posedge mclk);
      reg_read(cops_pkg::OFS_P2_PIN_STATE, rd_val);
      chk("p2 pin state", {14'h0000, rows[i].e2o}, {8'h00, rd_val});
      reg_read(cops_pkg::OFS_P3_PIN_STATE, rd_val);
      chk("p3 pin state", {9'h000, rows[i].e3[1], 6'h00}, {8'h00, rd_val});
    end
    $display("test table done");

    // Clocks on all three pins while each of their data bits is set
    fast_clock <= 1'b0;
    slow_clock <= 1'b0;
    reg_write(cops_pkg::OFS_P2_FUNC, 8'h03);
    reg_write(cops_pkg::OFS_P2_DRIVE_HI, 8'h03);
    reg_write(cops_pkg::OFS_P2_DRIVE_LO, 8'h03);
    reg_write(cops_pkg::OFS_P2_VALUE, 8'h03);
    reg_write(cops_pkg::OFS_P3_FUNC_HI, 8'h00);
    reg_write(cops_pkg::OFS_P3_FUNC_LO, 8'h40);
    reg_write(cops_pkg::OFS_P3_DIR, 8'h00);
    reg_write(cops_pkg::OFS_P3_DRIVE_HI, 8'h40);
    reg_write(cops_pkg::OFS_P3_DRIVE_LO, 8'h40);
    reg_write(cops_pkg::OFS_P3_VALUE, 8'h40);
    repeat (4) @(posedge mclk);
    clr <= 1'b0;
    fork
      repeat (10) begin
        repeat (3) @(posedge mclk);
        fast_clock <= ~fast_clock;
      end
      repeat (6) begin
        repeat (7) @(posedge mclk);
        slow_clock <= ~slow_clock;
      end
    join
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    chk("fast rises", 16'h0005, fast_rises);
    chk("slow a rises", 16'h0003, slow_a_rises);
    chk("slow b rises", 16'h0003, slow_b_rises);
    @(posedge mclk);
    $display("test clocks done");

    foreach (REGS[i]) begin
      reg_write(REGS[i], 8'hFF);
      reg_read(REGS[i], rd_val);
      chk("readback", (i < 4) ? 16'h0003 : 16'h007F, {8'h00, rd_val});
    end
    reg_write(16'hF215, 8'hFF);
    reg_read(16'hF215, rd_val);
    chk("unmapped", 16'h0000, {8'h00, rd_val});
    $display("test access done");

    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    chk("oe in reset", 16'h0000, {7'h00, p2_pin_oe, p3_pin_oe});
    rst <= 1'b0;
    @(posedge mclk);
    reg_read(cops_pkg::OFS_P2_FUNC, rd_val);
    chk("func after reset", 16'h0000, {8'h00, rd_val});
    $display("test mid reset done");
    stop_test();
  end
endmodule
`default_nettype wire
